// ### src/eth_port_pkg.sv
// Purpose: Shared constants and carriers for the Ethernet port flow-control block
// Assumes: 100 MHz system clock
// Notes:   Strap and clock indexes address the synchronised pin vectors
package eth_port_pkg;
	localparam int unsigned CLK_HZ    = 100_000_000;
	localparam int unsigned FAST_HZ   = 25_000_000;
	localparam int unsigned SLOW_HZ   = 2_500_000;
	localparam logic [5:0]  HALF_FAST = 6'(CLK_HZ / (2 * FAST_HZ) - 1);
	localparam logic [5:0]  HALF_SLOW = 6'(CLK_HZ / (2 * SLOW_HZ) - 1);
	localparam logic [4:0]  JAM_BYTES = 5'h04;
	localparam logic [15:0] MIN_LEN   = 16'h0040;
	localparam logic [3:0]  MII_SFD   = 4'hD;
	localparam logic [1:0]  RMII_SFD  = 2'h3;
	localparam logic [3:0]  JAM_NIB   = 4'h5;
	localparam logic [13:0] UNIT_MAX  = 14'h3FFF;
	localparam int          STRAP_RMII = 0;
	localparam int          STRAP_DCE  = 1;
	localparam int          CK_REF = 0;
	localparam int          CK_RX  = 1;
	localparam int          CK_TX  = 2;
	localparam int          PIN_DV = 5;
	localparam int          PIN_ER = 4;

	typedef enum logic [1:0] {RX_IDLE, RX_PRE, RX_DATA} rx_state_t;

	// Frame checks from the MAC core, valid at frame end
	typedef struct packed {
		logic crc_err;
		logic len_err;
		logic ctrl;
		logic unsup;
		logic collision;
	} rx_check_t;

	// Reject selects: 1 drops a frame with that condition (ctrl drops only in full duplex)
	typedef struct packed {
		logic rx_er;
		logic dribble;
		logic crc;
		logic len;
		logic ctrl;
		logic unsup;
	} rx_reject_t;

	typedef struct packed {
		logic        too_long;
		logic        runt;
		logic        collision;
		logic        unsupported_ctrl_frame_flag;
		logic        ctrl_frame_flag;
		logic        len_err;
		logic        crc_err;
		logic        dribble;
		logic        rx_er;
		logic [15:0] length;
	} rx_status_t;

	typedef struct packed {
		logic jabber;
		logic no_carrier;
		logic excess_defer;
		logic late_col;
		logic excess_col;
		logic underrun;
		logic deferred;
		logic collision;
		logic heartbeat;
	} tx_err_t;

	typedef struct packed {
		logic jabber;
		logic no_carrier;
		logic excess_defer;
		logic late_col;
		logic excess_col;
		logic underrun;
		logic deferred_resend_bit;
		logic collision;
		logic heartbeat_fail_resend_bit;
	} tx_resend_t;
endpackage

// ### src/eth_port_flow_ctrl.sv
// Purpose: MII/RMII port clocking, rx length limit, frame status, jam and pause
// Assumes: Link clocks are sampled by clk_i; MAC core supplies frame checks
// Notes:   Tags below mark the logic carrying each rule
// Functional notes
// R01: Half duplex jams first four incoming bytes
// R02: Frame in progress at crossing not jammed
// R03: Jam each new frame while above threshold
// R04: Busy bit request emits a pause frame
// R05: Jam enable bit starts manual jamming
// R06: Status flags control and unsupported frames
// R07: Reduced-pin mode uses 50 MHz reference
// R08: Media-independent mode uses 25 MHz clocks
// R09: Strap selects reduced-pin or media-independent
// R10: DCE derives 25 or 2.5 MHz clocks
// R11: In DTE the PHY drives clocks
// R12: Maximum frame length programmable, high/low bytes
// R13: Length counts address through CRC only
// R14: Overlong frames discarded, both directions
// R15: Status overwritten by each new frame
// R16: Transmit errors set transmit status bits
// R17: Per-error resend selects, deferred and heartbeat
// R18: No carrier optionally flushes transmit queue
// R19: Per-condition keep or drop received frames
// R20: Runts and collided frames always dropped
// R21: Strap selects DTE or DCE role; the code ignores it in reduced-pin mode
// R22: Auto flow control overrides software bits
`timescale 1ns/1ps
`default_nettype none
module eth_port_flow_ctrl (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     ce_i,
	input  wire logic                     reduced_pin_select_strap_i,
	input  wire logic                     port_role_select_strap_i,
	input  wire logic                     speed_100_i,
	input  wire logic                     half_duplex_i,
	input  wire logic                     auto_flow_ctrl_bit_i,
	input  wire logic                     jam_enable_bit_i,
	input  wire logic                     pause_send_busy_bit_i,
	input  wire logic                     flow_ctrl_enable_bit_i,
	input  wire logic                     pause_ack_i,
	input  wire logic                     rx_queue_high_threshold_i,
	input  wire logic [7:0]               rx_max_frame_size_high_i,
	input  wire logic [7:0]               rx_max_frame_size_low_i,
	input  wire eth_port_pkg::rx_reject_t rx_frame_reject_control_i,
	input  wire eth_port_pkg::rx_check_t  rx_check_i,
	input  wire eth_port_pkg::tx_resend_t tx_frame_resend_control_i,
	input  wire logic                     no_carrier_flush_bit_i,
	input  wire logic                     tx_done_i,
	input  wire eth_port_pkg::tx_err_t    tx_err_i,
	input  wire logic                     pp_frame_end_i,
	input  wire logic [15:0]              pp_frame_len_i,
	input  wire logic                     ref_clk_i,
	input  wire logic                     rx_clk_i,
	input  wire logic                     tx_clk_i,
	input  wire logic                     rx_dv_i,
	input  wire logic                     rx_er_i,
	input  wire logic [3:0]               rxd_i,
	output logic                          rx_clk_o,
	output logic                          rx_clk_oe_o,
	output logic                          tx_clk_o,
	output logic                          tx_clk_oe_o,
	output logic                          tx_en_o,
	output logic [3:0]                    txd_o,
	output eth_port_pkg::rx_status_t      rx_frame_status_o,
	output logic                          rx_ok_o,
	output logic                          rx_drop_o,
	output logic                          pp_drop_o,
	output eth_port_pkg::tx_err_t         tx_frame_status_o,
	output logic                          tx_resend_o,
	output logic                          tx_flush_o,
	output logic                          pause_req_o,
	output logic                          fce_o
);
	typedef struct packed {
		logic [2:0]              ck_s1;
		logic [2:0]              ck_s2;
		logic [2:0]              ck_d;
		logic [1:0]              strap_s1;
		logic [1:0]              strap_s2;
		logic [5:0]              pin_s1;
		logic [5:0]              pin_s2;
		logic [5:0]              div_cnt;
		logic                    gclk;
		logic                    clk_oe;
		eth_port_pkg::rx_state_t rx_st;
		logic [13:0]             units;
		logic                    er_seen;
		logic [4:0]              jam_left;
		logic                    tx_en;
		logic [3:0]              txd;
		eth_port_pkg::rx_status_t rx_stat;
		logic                    rx_ok;
		logic                    rx_drop;
		logic                    pp_drop;
		eth_port_pkg::tx_err_t   tx_stat;
		logic                    resend;
		logic                    flush;
		logic                    pause_req;
		logic                    fcb_d;
		logic                    fce;
	} state_t;
	state_t st_r;
	state_t st_nxt;
	// Bytes seen, from link units (nibbles or dibits)
	function automatic logic [15:0] unit_bytes(input logic [13:0] u, input logic rmii);
		unit_bytes = rmii ? {4'h0, u[13:2]} : {3'h0, u[13:1]};
	endfunction
	// Link units making up the jam
	function automatic logic [4:0] jam_units(input logic rmii);
		jam_units = rmii ? 5'(eth_port_pkg::JAM_BYTES * 4) : 5'(eth_port_pkg::JAM_BYTES * 2);
	endfunction

	logic        rmii;
	logic        dce;
	logic [5:0]  half;
	logic        gtog;
	logic        gedge;
	logic [2:0]  ext_edge;
	logic        rx_unit;
	logic        tx_unit;
	logic        dv;
	logic        rx_start;
	logic        rx_end;
	logic        jam_go;
	logic [15:0] max_len;
	logic [15:0] bytes;
	logic        drop;
	logic        sfd;

	// Mode decode, clock edges and frame events
	always_comb
	begin
		rmii = st_r.strap_s2[eth_port_pkg::STRAP_RMII]; // R09
		dce = st_r.strap_s2[eth_port_pkg::STRAP_DCE] & ~rmii; // R21
		half = speed_100_i ? eth_port_pkg::HALF_FAST : eth_port_pkg::HALF_SLOW;
		gtog = dce && (st_r.div_cnt >= half);
		gedge = gtog && !st_r.gclk;
		ext_edge = st_r.ck_s2 & ~st_r.ck_d;
		rx_unit = rmii ? ext_edge[eth_port_pkg::CK_REF] // R07
			: dce ? gedge : ext_edge[eth_port_pkg::CK_RX]; // R08 R11
		tx_unit = rmii ? ext_edge[eth_port_pkg::CK_REF]
			: dce ? gedge : ext_edge[eth_port_pkg::CK_TX];
		dv = st_r.pin_s2[eth_port_pkg::PIN_DV];
		rx_start = rx_unit && dv && (st_r.rx_st == eth_port_pkg::RX_IDLE);
		rx_end = rx_unit && !dv && (st_r.rx_st != eth_port_pkg::RX_IDLE);
		jam_go = half_duplex_i && (auto_flow_ctrl_bit_i ? rx_queue_high_threshold_i
			: jam_enable_bit_i); // R03 R05 R22
		max_len = {rx_max_frame_size_high_i, rx_max_frame_size_low_i}; // R12
		bytes = unit_bytes(st_r.units, rmii);
		sfd = rmii ? (st_r.pin_s2[1:0] == eth_port_pkg::RMII_SFD)
			: (st_r.pin_s2[3:0] == eth_port_pkg::MII_SFD);
	end

	// Next-state logic
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ck_s1 = {tx_clk_i, rx_clk_i, ref_clk_i};
		st_nxt.ck_s2 = st_r.ck_s1;
		st_nxt.ck_d = st_r.ck_s2;
		st_nxt.strap_s1 = {port_role_select_strap_i, reduced_pin_select_strap_i};
		st_nxt.strap_s2 = st_r.strap_s1;
		st_nxt.pin_s1 = {rx_dv_i, rx_er_i, rxd_i};
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.rx_ok = 1'b0;
		st_nxt.rx_drop = 1'b0;
		st_nxt.pp_drop = 1'b0;
		st_nxt.resend = 1'b0;
		st_nxt.flush = 1'b0;
		drop = 1'b0;

		// DCE clock divider driving both link clocks
		st_nxt.clk_oe = dce; // R10
		if (gtog)
		begin
			st_nxt.div_cnt = '0;
			st_nxt.gclk = ~st_r.gclk; // R10
		end
		else
			st_nxt.div_cnt = dce ? st_r.div_cnt + 6'h01 : '0;

		// Receive framing and length count after the delimiter
		if (rx_unit)
		begin
			unique case (st_r.rx_st)
				eth_port_pkg::RX_IDLE:
					if (dv)
						st_nxt.rx_st = eth_port_pkg::RX_PRE;
				eth_port_pkg::RX_PRE:
					if (!dv)
						st_nxt.rx_st = eth_port_pkg::RX_IDLE;
					else if (sfd)
						st_nxt.rx_st = eth_port_pkg::RX_DATA; // R13
				eth_port_pkg::RX_DATA:
					if (!dv)
						st_nxt.rx_st = eth_port_pkg::RX_IDLE;
					else if (st_r.units != eth_port_pkg::UNIT_MAX)
						st_nxt.units = st_r.units + 14'h0001; // R13
			endcase
			if (dv && st_r.pin_s2[eth_port_pkg::PIN_ER])
				st_nxt.er_seen = 1'b1;
		end
		if (rx_start)
		begin
			st_nxt.units = '0;
			st_nxt.er_seen = st_r.pin_s2[eth_port_pkg::PIN_ER];
		end

		// Frame end: status overwrite and keep/drop decision
		if (rx_end)
		begin
			st_nxt.rx_stat.length = bytes; // R15
			st_nxt.rx_stat.too_long = bytes > max_len; // R14
			st_nxt.rx_stat.runt = bytes < eth_port_pkg::MIN_LEN;
			st_nxt.rx_stat.collision = rx_check_i.collision;
			st_nxt.rx_stat.unsupported_ctrl_frame_flag = rx_check_i.unsup; // R06
			st_nxt.rx_stat.ctrl_frame_flag = rx_check_i.ctrl; // R06
			st_nxt.rx_stat.len_err = rx_check_i.len_err;
			st_nxt.rx_stat.crc_err = rx_check_i.crc_err;
			st_nxt.rx_stat.dribble = rmii ? |st_r.units[1:0] : st_r.units[0];
			st_nxt.rx_stat.rx_er = st_r.er_seen;
			drop = st_nxt.rx_stat.too_long | st_nxt.rx_stat.runt // R14 R20
				| rx_check_i.collision // R20
				| (rx_frame_reject_control_i.rx_er & st_r.er_seen) // R19
				| (rx_frame_reject_control_i.dribble & st_nxt.rx_stat.dribble)
				| (rx_frame_reject_control_i.crc & rx_check_i.crc_err)
				| (rx_frame_reject_control_i.len & rx_check_i.len_err)
				| (rx_frame_reject_control_i.ctrl & rx_check_i.ctrl & ~half_duplex_i)
				| (rx_frame_reject_control_i.unsup & rx_check_i.unsup);
			st_nxt.rx_ok = ~drop;
			st_nxt.rx_drop = drop;
		end

		// Frames from the packet processor checked against the same limit
		st_nxt.pp_drop = pp_frame_end_i && (pp_frame_len_i > max_len); // R14

		// Jam output: leading bytes of each new frame while armed
		if (tx_unit)
		begin
			st_nxt.tx_en = st_r.jam_left != '0; // R01
			st_nxt.txd = (st_r.jam_left != '0) ? eth_port_pkg::JAM_NIB : 4'h0;
			if (st_r.jam_left != '0)
				st_nxt.jam_left = st_r.jam_left - 5'h01;
		end
		if (rx_start && jam_go)
			st_nxt.jam_left = jam_units(rmii); // R01 R02 R03

		// Transmit status, resend and flush decisions
		if (tx_done_i)
		begin
			st_nxt.tx_stat = tx_err_i; // R15 R16
			st_nxt.resend = |(tx_err_i & tx_frame_resend_control_i); // R17
			st_nxt.flush = tx_err_i.no_carrier & no_carrier_flush_bit_i; // R18
		end

		// Pause requests: manual on busy-bit rise with flow control enabled, automatic at frame end above threshold in full duplex
		st_nxt.fcb_d = pause_send_busy_bit_i;
		st_nxt.fce = auto_flow_ctrl_bit_i ? rx_queue_high_threshold_i
			: flow_ctrl_enable_bit_i; // R22
		st_nxt.pause_req = (st_r.pause_req & ~pause_ack_i)
			| (!auto_flow_ctrl_bit_i && flow_ctrl_enable_bit_i
				&& pause_send_busy_bit_i && !st_r.fcb_d) // R04
			| (auto_flow_ctrl_bit_i && !half_duplex_i
				&& rx_queue_high_threshold_i && rx_end); // R22
	end

	// State register with clock enable
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			st_r <= '0;
		else if (ce_i)
			st_r <= st_nxt;
	end

	// Outputs straight from the state register
	assign rx_clk_o = st_r.gclk;
	assign tx_clk_o = st_r.gclk;
	assign rx_clk_oe_o = st_r.clk_oe;
	assign tx_clk_oe_o = st_r.clk_oe;
	assign tx_en_o = st_r.tx_en;
	assign txd_o = st_r.txd;
	assign rx_frame_status_o = st_r.rx_stat;
	assign rx_ok_o = st_r.rx_ok;
	assign rx_drop_o = st_r.rx_drop;
	assign pp_drop_o = st_r.pp_drop;
	assign tx_frame_status_o = st_r.tx_stat;
	assign tx_resend_o = st_r.resend;
	assign tx_flush_o = st_r.flush;
	assign pause_req_o = st_r.pause_req;
	assign fce_o = st_r.fce;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_jam_load;
		ce_i && rx_start && jam_go |=> st_r.jam_left == jam_units($past(rmii));
	endproperty
	a_jam_load: assert property (p_jam_load) else $error("jam not loaded"); // R01
	property p_no_jam;
		ce_i && rx_start && !jam_go && st_r.jam_left == '0 && !tx_unit
			|=> st_r.jam_left == '0;
	endproperty
	a_no_jam: assert property (p_no_jam) else $error("jam without cause"); // R03
	property p_dce_clk;
		ce_i && gtog |=> tx_clk_o != $past(tx_clk_o) && rx_clk_o == tx_clk_o;
	endproperty
	a_dce_clk: assert property (p_dce_clk) else $error("divider stuck"); // R10
	property p_pp_drop;
		ce_i && pp_frame_end_i && pp_frame_len_i > max_len |=> pp_drop_o;
	endproperty
	a_pp_drop: assert property (p_pp_drop) else $error("long pp frame kept"); // R14
	property p_tx_stat;
		ce_i && tx_done_i |=> tx_frame_status_o == $past(tx_err_i);
	endproperty
	a_tx_stat: assert property (p_tx_stat) else $error("tx status stale"); // R16
	property p_resend;
		ce_i && tx_done_i && |(tx_err_i & tx_frame_resend_control_i) |=> tx_resend_o;
	endproperty
	a_resend: assert property (p_resend) else $error("resend missed"); // R17
	property p_flush;
		ce_i && tx_done_i && tx_err_i.no_carrier && no_carrier_flush_bit_i
			|=> tx_flush_o ##1 (!tx_flush_o || !$past(ce_i) || $past(tx_done_i));
	endproperty
	a_flush: assert property (p_flush) else $error("flush missed"); // R18
	property p_runt_drop;
		ce_i && rx_end && (bytes < eth_port_pkg::MIN_LEN || rx_check_i.collision)
			|=> rx_drop_o && !rx_ok_o;
	endproperty
	a_runt_drop: assert property (p_runt_drop) else $error("runt kept"); // R20
	property p_pause;
		ce_i && !auto_flow_ctrl_bit_i && flow_ctrl_enable_bit_i
			&& pause_send_busy_bit_i && !st_r.fcb_d |=> pause_req_o;
	endproperty
	a_pause: assert property (p_pause) else $error("pause not requested"); // R04
endmodule
`default_nettype wire

// ### tb/phy_model.sv
// Purpose: Behavioural PHY that drives the receive side of the port
// Assumes: Link clock period 125 ns; the clock stands still between frames
// Notes:   Data changes while the link clock is low; idle data toggles
`timescale 1ns/1ps
`default_nettype none
module phy_model (
	output logic       link_clk_o,
	output logic       rx_dv_o,
	output logic [3:0] rxd_o
);
	// Idle lines at time zero
	initial
	begin
		link_clk_o = 1'b0;
		rx_dv_o    = 1'b0;
		rxd_o      = 4'h0;
	end

	// One unit, data set up half a period ahead of the rising edge
	task automatic drive_unit(input logic dv, input logic [3:0] d);
		rx_dv_o = dv;
		rxd_o   = d;
		#62.5 link_clk_o = 1'b1;
		#62.5 link_clk_o = 1'b0;
	endtask

	// Preamble, delimiter, data low bits first, then idle edges
	task automatic send_frame(input int nbytes, input logic rmii);
		int w;
		w = rmii ? 2 : 4;
		#2;
		repeat (4) drive_unit(1'b1, rmii ? 4'h1 : 4'h5);
		drive_unit(1'b1, rmii ? 4'h3 : 4'hD);
		for (int i = 0; i < nbytes; i++)
			for (int k = 0; k < 8 / w; k++)
				drive_unit(1'b1, 4'((8'(i) ^ 8'hA6) >> (k * w)) & (rmii ? 4'h3 : 4'hF));
		repeat (12) drive_unit(1'b0, ~rxd_o);
	endtask
endmodule
`default_nettype wire

// ### tb/ethernet_port_flow_control_tb.sv
// Purpose: Self-checking bench for the port flow-control block
// Assumes: 100 MHz clock; link clock from the PHY model
// Notes:   Pulses are counted on the clock, jam units on the tx clock
`timescale 1ns/1ps
`default_nettype none
module ethernet_port_flow_control_tb;
	logic                       clk_i = 1'b0;
	logic                       rst_i = 1'b1;
	logic                       reduced_pin_select_strap_i = 1'b0, port_role_select_strap_i = 1'b0;
	logic                       speed_100_i = 1'b1, half_duplex_i = 1'b0, auto_flow_ctrl_bit_i = 1'b0;
	logic                       jam_enable_bit_i = 1'b0, pause_send_busy_bit_i = 1'b0;
	logic                       flow_ctrl_enable_bit_i = 1'b0, pause_ack_i = 1'b0;
	logic                       rx_queue_high_threshold_i = 1'b0, no_carrier_flush_bit_i = 1'b0;
	logic                       tx_done_i = 1'b0, pp_frame_end_i = 1'b0, rx_er_i = 1'b0;
	logic [7:0]                 rx_max_frame_size_high_i = 8'h00, rx_max_frame_size_low_i = 8'h40;
	logic [15:0]                pp_frame_len_i = 16'h0000;
	eth_port_pkg::rx_reject_t   rx_frame_reject_control_i = '0;
	eth_port_pkg::rx_check_t    rx_check_i = '0;
	eth_port_pkg::tx_resend_t   tx_frame_resend_control_i = '0;
	eth_port_pkg::tx_err_t      tx_err_i = '0;
	logic                       link_clk, rx_dv_i, rx_clk_o, rx_clk_oe_o, tx_clk_o, tx_clk_oe_o;
	logic                       tx_en_o, rx_ok_o, rx_drop_o, pp_drop_o, tx_resend_o, tx_flush_o;
	logic                       pause_req_o, fce_o;
	logic [3:0]                 rxd_i, txd_o;
	wire logic                  ref_clk_i, rx_clk_i, tx_clk_i;
	eth_port_pkg::rx_status_t   rx_frame_status_o;
	eth_port_pkg::tx_err_t      tx_frame_status_o;
	int                         errors = 0, samples_checked = 0, ok_cnt = 0, drop_cnt = 0;
	int                         jam_cnt = 0, jam_bad = 0, cycles = 0;

	// Clock; link clock pins follow whoever drives them
	always #5 clk_i = ~clk_i;
	assign ref_clk_i = link_clk;
	assign rx_clk_i  = rx_clk_oe_o ? rx_clk_o : link_clk;
	assign tx_clk_i  = tx_clk_oe_o ? tx_clk_o : link_clk;

	eth_port_flow_ctrl uut (
		.clk_i, .rst_i, .ce_i(1'b1), .reduced_pin_select_strap_i, .port_role_select_strap_i,
		.speed_100_i, .half_duplex_i, .auto_flow_ctrl_bit_i, .jam_enable_bit_i,
		.pause_send_busy_bit_i, .flow_ctrl_enable_bit_i, .pause_ack_i, .rx_queue_high_threshold_i,
		.rx_max_frame_size_high_i, .rx_max_frame_size_low_i, .rx_frame_reject_control_i,
		.rx_check_i, .tx_frame_resend_control_i, .no_carrier_flush_bit_i, .tx_done_i, .tx_err_i,
		.pp_frame_end_i, .pp_frame_len_i, .ref_clk_i, .rx_clk_i, .tx_clk_i, .rx_dv_i,
		.rx_er_i, .rxd_i, .rx_clk_o, .rx_clk_oe_o, .tx_clk_o, .tx_clk_oe_o, .tx_en_o, .txd_o,
		.rx_frame_status_o, .rx_ok_o, .rx_drop_o, .pp_drop_o, .tx_frame_status_o, .tx_resend_o,
		.tx_flush_o, .pause_req_o, .fce_o
	);

	phy_model phy (.link_clk_o(link_clk), .rx_dv_o(rx_dv_i), .rxd_o(rxd_i));

	// Pulse counters and hang guard
	always @(posedge clk_i)
	begin
		cycles++;
		if (rx_ok_o === 1'b1) ok_cnt++;
		if (rx_drop_o === 1'b1) drop_cnt++;
		if (cycles == 90000)
		begin
			errors++;
			results();
		end
	end

	// Jam units seen on the transmit clock
	always @(posedge tx_clk_i)
	begin
		if (tx_en_o === 1'b1) jam_cnt++;
		if (tx_en_o === 1'b1 && txd_o !== eth_port_pkg::JAM_NIB) jam_bad++;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results();
		$display("Checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic reset_dut();
		rst_i = 1'b1;
		repeat (6) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clk_i);
	endtask

	// One received frame, expecting accept or drop
	task automatic frame(input int n, input logic rmii, input logic ok);
		int o, d;
		o = ok_cnt;
		d = drop_cnt;
		phy.send_frame(n, rmii);
		@(negedge clk_i);
		check("rx_ok", 32'(ok_cnt - o), 32'(ok));
		check("rx_drop", 32'(drop_cnt - d), 32'(!ok));
	endtask

	task automatic t_length();
		frame(64, 1'b0, 1'b1);
		check("length", 32'(rx_frame_status_o.length), 32'h40);
		frame(65, 1'b0, 1'b0);
		check("too_long", 32'(rx_frame_status_o.too_long), 32'h1);
		check("length", 32'(rx_frame_status_o.length), 32'h41);
		frame(63, 1'b0, 1'b0);
		check("runt", 32'(rx_frame_status_o.runt), 32'h1);
		rx_max_frame_size_low_i = 8'h41;
		frame(65, 1'b0, 1'b1);
	endtask

	// Each frame check kept, then dropped; collision always dropped
	task automatic t_reject();
		for (int i = 0; i < 4; i++)
		begin
			rx_check_i = 5'(5'h10 >> i);
			rx_frame_reject_control_i = '0;
			frame(64, 1'b0, 1'b1);
			rx_frame_reject_control_i = 6'(6'h08 >> i);
			frame(64, 1'b0, 1'b0);
			check("ctrl_flag", 32'(rx_frame_status_o.ctrl_frame_flag), 32'(i == 2));
			check("crc_flag", 32'(rx_frame_status_o.crc_err), 32'(i == 0));
			check("len_flag", 32'(rx_frame_status_o.len_err), 32'(i == 1));
		end
		check("unsup_flag", 32'(rx_frame_status_o.unsupported_ctrl_frame_flag), 32'h1);
		rx_check_i = 5'h01;
		rx_frame_reject_control_i = '0;
		frame(64, 1'b0, 1'b0);
		check("col_flag", 32'(rx_frame_status_o.collision), 32'h1);
		rx_check_i = '0;
		rx_er_i = 1'b1;
		rx_frame_reject_control_i = 6'h20;
		frame(64, 1'b0, 1'b0);
		check("rx_er_flag", 32'(rx_frame_status_o.rx_er), 32'h1);
		rx_er_i = 1'b0;
		rx_frame_reject_control_i = '0;
	endtask

	task automatic jam_frame(input int exp);
		jam_cnt = 0;
		jam_bad = 0;
		phy.send_frame(64, 1'b0);
		@(negedge clk_i);
		check("jam_units", 32'(jam_cnt), 32'(exp));
		check("jam_nibble", 32'(jam_bad), 32'h0);
	endtask

	task automatic t_jam();
		half_duplex_i = 1'b1;
		jam_enable_bit_i = 1'b1;
		jam_frame(8);
		auto_flow_ctrl_bit_i = 1'b1;
		jam_frame(0);
		fork
			jam_frame(0);
			begin
				repeat (600) @(negedge clk_i);
				rx_queue_high_threshold_i = 1'b1;
			end
		join
		jam_frame(8);
		rx_queue_high_threshold_i = 1'b0;
		jam_frame(0);
		half_duplex_i = 1'b0;
		auto_flow_ctrl_bit_i = 1'b0;
		jam_enable_bit_i = 1'b0;
	endtask

	task automatic ack_pause();
		pause_ack_i = 1'b1;
		@(negedge clk_i);
		pause_ack_i = 1'b0;
		@(negedge clk_i);
		check("pause_clear", 32'(pause_req_o), 32'h0);
	endtask

	task automatic t_pause();
		flow_ctrl_enable_bit_i = 1'b1;
		@(negedge clk_i);
		check("fce", 32'(fce_o), 32'h1);
		pause_send_busy_bit_i = 1'b1;
		repeat (2) @(negedge clk_i);
		check("pause_req", 32'(pause_req_o), 32'h1);
		ack_pause();
		pause_send_busy_bit_i = 1'b0;
		flow_ctrl_enable_bit_i = 1'b0;
		auto_flow_ctrl_bit_i = 1'b1;
		repeat (2) @(negedge clk_i);
		pause_send_busy_bit_i = 1'b1;
		rx_queue_high_threshold_i = 1'b1;
		repeat (2) @(negedge clk_i);
		check("pause_ignored", 32'(pause_req_o), 32'h0);
		check("fce_auto", 32'(fce_o), 32'h1);
		frame(64, 1'b0, 1'b1);
		check("pause_auto", 32'(pause_req_o), 32'h1);
		ack_pause();
		rx_queue_high_threshold_i = 1'b0;
		auto_flow_ctrl_bit_i = 1'b0;
		pause_send_busy_bit_i = 1'b0;
	endtask

	task automatic tx_pulse(input logic [8:0] err, input logic [8:0] res, input logic fl);
		tx_err_i = err;
		tx_frame_resend_control_i = res;
		tx_done_i = 1'b1;
		@(negedge clk_i);
		tx_done_i = 1'b0;
		check("tx_status", 32'(tx_frame_status_o), 32'(err));
		check("tx_resend", 32'(tx_resend_o), 32'(|(err & res)));
		check("tx_flush", 32'(tx_flush_o), 32'(fl));
		@(negedge clk_i);
	endtask

	task automatic t_tx();
		no_carrier_flush_bit_i = 1'b1;
		for (int i = 0; i < 9; i++)
			tx_pulse(9'(9'h001 << i), 9'h155, i == 7);
		no_carrier_flush_bit_i = 1'b0;
		tx_pulse(9'h080, 9'h000, 1'b0);
	endtask

	// Limit is 41h here: one over is dropped, the limit itself kept
	task automatic t_pp();
		for (int i = 0; i < 2; i++)
		begin
			pp_frame_len_i = 16'h0042 - 16'(i);
			pp_frame_end_i = 1'b1;
			@(negedge clk_i);
			pp_frame_end_i = 1'b0;
			check("pp_drop", 32'(pp_drop_o), 32'(i == 0));
			@(negedge clk_i);
		end
	endtask

	task automatic half_time(input logic [5:0] half);
		int n;
		n = 0;
		repeat (2) @(posedge tx_clk_o);
		@(negedge clk_i);
		while (tx_clk_o === 1'b1)
		begin
			n++;
			@(negedge clk_i);
		end
		check("rx_clk", 32'(rx_clk_o), 32'h0);
		check("clk_half", 32'(n), 32'(half) + 32'h1);
	endtask

	task automatic t_clocks();
		check("oe_dte", 32'({rx_clk_oe_o, tx_clk_oe_o}), 32'h0);
		port_role_select_strap_i = 1'b1;
		reset_dut();
		check("oe_dce", 32'({rx_clk_oe_o, tx_clk_oe_o}), 32'h3);
		half_time(eth_port_pkg::HALF_FAST);
		speed_100_i = 1'b0;
		half_time(eth_port_pkg::HALF_SLOW);
		reduced_pin_select_strap_i = 1'b1;
		reset_dut();
		check("oe_rmii", 32'({rx_clk_oe_o, tx_clk_oe_o}), 32'h0);
		frame(64, 1'b1, 1'b1);
		check("rmii_length", 32'(rx_frame_status_o.length), 32'h40);
	endtask

	initial
	begin
		reset_dut();
		t_length();
		t_reject();
		t_jam();
		t_pause();
		t_tx();
		t_pp();
		t_clocks();
		results();
	end
endmodule
`default_nettype wire
